// ==== asrw_pkg.sv ====
// package: constants, types and register map of the serial receiver with wake-up
package asrw_pkg;

  // ==================================================
  // register byte offsets on the bus
  localparam logic [7:0] OFS_IRQ_FLAGS   = 8'h00;
  localparam logic [7:0] OFS_IRQ_ENABLES = 8'h04;
  localparam logic [7:0] OFS_IRQ_PRIO    = 8'h08;
  localparam logic [7:0] OFS_RX_STATUS   = 8'h0C;
  localparam logic [7:0] OFS_RX_DATA     = 8'h10;
  localparam logic [7:0] OFS_TX_STATUS   = 8'h14;
  localparam logic [7:0] OFS_BAUD_CTL    = 8'h18;
  localparam logic [7:0] OFS_DIV_HIGH    = 8'h1C;
  localparam logic [7:0] OFS_DIV_LOW     = 8'h20;

  // ==================================================
  // field positions
  localparam int BIT_RX_CPL     = 5; // flags, enables, priority
  localparam int BIT_SERIAL_PORT_ENABLE       = 7; // receive status
  localparam int BIT_RX9        = 6;
  localparam int BIT_SREN       = 5;
  localparam int BIT_CONTINUOUS_RECEIVE_ENABLE       = 4;
  localparam int BIT_ADDRESS_DETECT_ENABLE      = 3;
  localparam int BIT_FRAMING_ERROR_FLAG       = 2;
  localparam int BIT_OVERRUN_ERROR_FLAG       = 1;
  localparam int BIT_RECEIVED_NINTH_BIT       = 0;
  localparam int BIT_SYNC       = 4; // transmit status
  localparam int BIT_HS_BAUD    = 2;
  localparam int BIT_RX_IDLE    = 6; // baud control
  localparam int BIT_DIV16      = 3;
  localparam int BIT_WAKE       = 1;

  // ==================================================
  // timing
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hF; // 16 samples per bit
  localparam logic [3:0] MID_SAMPLE      = 4'h7;
  localparam logic [1:0] SLOW_PRESCALE   = 2'h3; // x64 mode: 4 divisor periods per sample
  localparam logic [3:0] LAST_BIT_8      = 4'h7;
  localparam logic [3:0] LAST_BIT_9      = 4'h8;

  // ==================================================
  // receiver states
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } asrw_rx_e;

  // ==================================================
  // complete block state
  typedef struct packed {
    asrw_rx_e    st;
    logic [3:0]  tick;
    logic [3:0]  bitn;
    logic [8:0]  shift;
    logic [15:0] brg;
    logic [1:0]  pre;
    logic        rx_prev;
    logic        woke;
    logic [7:0]  rdata;
    logic        ninth;
    logic        full;
    logic        wake_flag;
    logic        framing_error_flag;
    logic        overrun_error_flag;
    logic        serial_port_enable;
    logic        rx9;
    logic        sren;
    logic        continuous_receive_enable;
    logic        address_detect_enable;
    logic        receive_interrupt_enable;
    logic        receive_interrupt_priority;
    logic        sync;
    logic        high_speed_baud_select;
    logic        sixteen_bit_divisor_select;
    logic        wakeup_enable;
    logic [7:0]  div_hi;
    logic [7:0]  div_lo;
    logic        d_wr;
    logic [7:0]  d_addr;
    logic [31:0] hrdata;
  } asrw_state_s;

  localparam asrw_state_s STATE_RST = '0;

  // ahb signals from master
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } asrw_ahb_req_s;

endpackage : asrw_pkg

// ==== asrw_receiver.sv ====
// serial receiver with address detect and wake-up, ahb-lite register slave
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - sixteen-fold sampling feeds bit-rate shifter
// - baud from 8/16-bit divisor and speed bits
// - async only when sync clear, port enabled
// - frames accepted only with continuous receive
// - nine-bit mode keeps ninth bit in status
// - frame sets complete flag; irq if enabled
// - low eight data bits in data register
// - errors held until receive enable cleared
// - priority bit routes irq high or low
// - address detect drops non-address frames in nine-bit mode
// - sleep stops receiver baud clocks
// - wake-up only in asynchronous mode
// - wake enable suppresses reception, stays idle
// - falling receive line is wake event
// - wake event sets complete flag
// - data register read clears wake flag
// - rising edge after wake clears enable
// - frame: start, 8/9 data, one stop
// - data assembled least significant first
module asrw_receiver (
  // clock and reset
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_n_i,
  // ahb-lite slave
  input  wire asrw_pkg::asrw_ahb_req_s ahb_i,
  output logic                       hreadyout_o,
  output logic                       hresp_o,
  output logic [31:0]                hrdata_o,
  // serial line and power state
  input  wire logic                  receive_line_i,
  input  wire logic                  sleep_i,
  // interrupt requests
  output logic                       irq_high_o,
  output logic                       irq_low_o
);
  import asrw_pkg::*;

  // ==================================================
  // state and shared terms
  asrw_state_s state_reg;
  asrw_state_s state_next;

  logic        async_en;
  logic        samp;
  logic        base_pulse;
  logic [15:0] divisor;
  logic [15:0] reload;
  logic        receive_complete_flag;
  logic        frame_done;
  logic        keep_frame;
  logic        frame_ninth;
  logic [7:0]  frame_byte;
  logic        wake_fall;
  logic        wake_rise;
  logic        addr_ph;
  logic        rd_rx_data;

  assign async_en   = state_reg.serial_port_enable & ~state_reg.sync;
  assign divisor    = state_reg.sixteen_bit_divisor_select ? {state_reg.div_hi, state_reg.div_lo}
                                      : {8'h00, state_reg.div_lo};
  assign reload     = (state_reg.sixteen_bit_divisor_select & state_reg.high_speed_baud_select) ? (divisor >> 2) : divisor;
  assign base_pulse = (state_reg.brg == 16'h0000);
  assign samp       = async_en & ~sleep_i & base_pulse &
                      ((state_reg.sixteen_bit_divisor_select | state_reg.high_speed_baud_select) | (state_reg.pre == SLOW_PRESCALE));
  assign frame_done = samp & (state_reg.st == RX_STOP) & (state_reg.tick == OVERSAMPLE_LAST)
                      & state_reg.continuous_receive_enable & ~state_reg.wakeup_enable;
  assign frame_ninth = state_reg.rx9 ? state_reg.shift[8] : 1'b0;
  assign frame_byte  = state_reg.rx9 ? state_reg.shift[7:0] : state_reg.shift[8:1];
  assign keep_frame  = ~(state_reg.address_detect_enable & state_reg.rx9 & ~frame_ninth);
  // wake edges only in async mode
  assign wake_fall  = async_en & state_reg.wakeup_enable & ~state_reg.woke
                      & state_reg.rx_prev & ~receive_line_i;
  assign wake_rise  = async_en & state_reg.wakeup_enable & state_reg.woke
                      & ~state_reg.rx_prev & receive_line_i;
  assign addr_ph    = ahb_i.hsel & ahb_i.hready & ahb_i.htrans[1];
  assign rd_rx_data = addr_ph & ~ahb_i.hwrite & (ahb_i.haddr[7:0] == OFS_RX_DATA);
  assign receive_complete_flag       = state_reg.full | state_reg.wake_flag;

  // ==================================================
  // next-state logic
  always_comb begin
    state_next = state_reg;
    state_next.rx_prev = receive_line_i;

    // baud generator
    if (async_en && !sleep_i) begin
      if (base_pulse) begin
        state_next.brg = reload;
        state_next.pre = 2'(state_reg.pre + 2'h1);
      end else begin
        state_next.brg = 16'(state_reg.brg - 16'h0001);
      end
    end

    if (samp) begin
      case (state_reg.st)
        RX_IDLE: begin
          if (!receive_line_i) begin
            state_next.st   = RX_START;
            state_next.tick = 4'h0;
          end
        end
        RX_START: begin
          state_next.tick = 4'(state_reg.tick + 4'h1);
          if (state_reg.tick == MID_SAMPLE) begin
            state_next.tick = 4'h0;
            state_next.bitn = 4'h0;
            state_next.st   = receive_line_i ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          state_next.tick = 4'(state_reg.tick + 4'h1);
          if (state_reg.tick == OVERSAMPLE_LAST) begin
            state_next.shift = {receive_line_i, state_reg.shift[8:1]};
            state_next.bitn  = 4'(state_reg.bitn + 4'h1);
            if (state_reg.bitn == (state_reg.rx9 ? LAST_BIT_9 : LAST_BIT_8)) begin
              state_next.st = RX_STOP;
            end
          end
        end
        RX_STOP: begin
          state_next.tick = 4'(state_reg.tick + 4'h1);
          if (state_reg.tick == OVERSAMPLE_LAST) begin
            state_next.st = RX_IDLE;
          end
        end
        default: state_next.st = RX_IDLE;
      endcase
    end

    // read of data register clears the full and wake flags
    if (rd_rx_data) begin
      state_next.full = 1'b0;
      state_next.wake_flag = 1'b0;
    end

    // frame end with one stop bit
    if (frame_done && keep_frame) begin
      if (state_reg.full && !rd_rx_data) begin
        state_next.overrun_error_flag = 1'b1;
      end else begin
        state_next.full  = 1'b1;
        // low eight bits to data register
        state_next.rdata = frame_byte;
        state_next.ninth = frame_ninth;
        if (!receive_line_i) begin
          state_next.framing_error_flag = 1'b1;
        end
      end
    end

    if (wake_fall) begin
      state_next.woke      = 1'b1;
      state_next.wake_flag = 1'b1;
    end

    // ahb data phase write
    state_next.d_wr = addr_ph & ahb_i.hwrite;
    state_next.d_addr = ahb_i.haddr[7:0];
    if (state_reg.d_wr) begin
      case (state_reg.d_addr)
        OFS_IRQ_ENABLES: state_next.receive_interrupt_enable = ahb_i.hwdata[BIT_RX_CPL];
        OFS_IRQ_PRIO:    state_next.receive_interrupt_priority = ahb_i.hwdata[BIT_RX_CPL];
        OFS_RX_STATUS: begin
          state_next.serial_port_enable  = ahb_i.hwdata[BIT_SERIAL_PORT_ENABLE];
          state_next.rx9   = ahb_i.hwdata[BIT_RX9];
          state_next.sren  = ahb_i.hwdata[BIT_SREN];
          state_next.continuous_receive_enable  = ahb_i.hwdata[BIT_CONTINUOUS_RECEIVE_ENABLE];
          state_next.address_detect_enable = ahb_i.hwdata[BIT_ADDRESS_DETECT_ENABLE];
        end
        OFS_TX_STATUS: begin
          state_next.sync = ahb_i.hwdata[BIT_SYNC];
          state_next.high_speed_baud_select = ahb_i.hwdata[BIT_HS_BAUD];
        end
        OFS_BAUD_CTL: begin
          state_next.sixteen_bit_divisor_select = ahb_i.hwdata[BIT_DIV16];
          state_next.wakeup_enable   = ahb_i.hwdata[BIT_WAKE];
        end
        OFS_DIV_HIGH: state_next.div_hi = ahb_i.hwdata[7:0];
        OFS_DIV_LOW:  state_next.div_lo = ahb_i.hwdata[7:0];
        default: state_next.d_wr = 1'b0;
      endcase
    end

    if (wake_rise) begin
      state_next.wakeup_enable  = 1'b0;
      state_next.woke = 1'b0;
    end
    if (!state_reg.wakeup_enable) begin
      state_next.woke = 1'b0;
    end

    if (!state_reg.continuous_receive_enable || state_reg.wakeup_enable || !async_en) begin
      state_next.st = RX_IDLE;
    end
    if (!state_reg.continuous_receive_enable) begin
      state_next.framing_error_flag = 1'b0;
      state_next.overrun_error_flag = 1'b0;
    end

    // ahb read data, taken in address phase
    state_next.hrdata = 32'h0000_0000;
    if (addr_ph && !ahb_i.hwrite) begin
      case (ahb_i.haddr[7:0])
        OFS_IRQ_FLAGS:   state_next.hrdata[BIT_RX_CPL] = receive_complete_flag;
        OFS_IRQ_ENABLES: state_next.hrdata[BIT_RX_CPL] = state_reg.receive_interrupt_enable;
        OFS_IRQ_PRIO:    state_next.hrdata[BIT_RX_CPL] = state_reg.receive_interrupt_priority;
        OFS_RX_STATUS: begin
          state_next.hrdata[BIT_SERIAL_PORT_ENABLE]  = state_reg.serial_port_enable;
          state_next.hrdata[BIT_RX9]   = state_reg.rx9;
          state_next.hrdata[BIT_SREN]  = state_reg.sren;
          state_next.hrdata[BIT_CONTINUOUS_RECEIVE_ENABLE]  = state_reg.continuous_receive_enable;
          state_next.hrdata[BIT_ADDRESS_DETECT_ENABLE] = state_reg.address_detect_enable;
          state_next.hrdata[BIT_FRAMING_ERROR_FLAG]  = state_reg.framing_error_flag;
          state_next.hrdata[BIT_OVERRUN_ERROR_FLAG]  = state_reg.overrun_error_flag;
          state_next.hrdata[BIT_RECEIVED_NINTH_BIT]  = state_reg.ninth;
        end
        OFS_RX_DATA:     state_next.hrdata[7:0] = state_reg.rdata;
        OFS_TX_STATUS: begin
          state_next.hrdata[BIT_SYNC]    = state_reg.sync;
          state_next.hrdata[BIT_HS_BAUD] = state_reg.high_speed_baud_select;
        end
        OFS_BAUD_CTL: begin
          state_next.hrdata[BIT_RX_IDLE] = (state_reg.st == RX_IDLE);
          state_next.hrdata[BIT_DIV16]   = state_reg.sixteen_bit_divisor_select;
          state_next.hrdata[BIT_WAKE]    = state_reg.wakeup_enable;
        end
        OFS_DIV_HIGH:    state_next.hrdata[7:0] = state_reg.div_hi;
        OFS_DIV_LOW:     state_next.hrdata[7:0] = state_reg.div_lo;
        default:         state_next.hrdata = 32'h0000_0000;
      endcase
    end
  end

  // ==================================================
  // state register
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state_reg <= STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==================================================
  // outputs
  assign hreadyout_o = 1'b1;
  assign hresp_o     = 1'b0;
  assign hrdata_o    = state_reg.hrdata;
  assign irq_high_o  = receive_complete_flag & state_reg.receive_interrupt_enable & state_reg.receive_interrupt_priority;
  assign irq_low_o   = receive_complete_flag & state_reg.receive_interrupt_enable & ~state_reg.receive_interrupt_priority;

  // ==================================================
  // assertions
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  rx_disable_a: assert property (!state_reg.continuous_receive_enable |=> state_reg.st == RX_IDLE)
    else $error("receiver left idle without receive enable");
  wake_idle_a: assert property (state_reg.wakeup_enable |=> state_reg.st == RX_IDLE)
    else $error("receiver active while wake-up enabled");
  err_clear_a: assert property (!state_reg.continuous_receive_enable |=> !state_reg.framing_error_flag && !state_reg.overrun_error_flag)
    else $error("error flag survived receive disable");
  sleep_halt_a: assert property (sleep_i |-> !samp ##1 $stable(state_reg.brg) || !sleep_i)
    else $error("baud generator ran during sleep");
  wake_flag_a: assert property (wake_fall |=> receive_complete_flag && state_reg.woke)
    else $error("wake event did not set complete flag");
  wake_end_a: assert property (wake_rise |=> !state_reg.wakeup_enable ##1 !state_reg.woke)
    else $error("wake enable not cleared by rising edge");
  read_clear_a: assert property (rd_rx_data && !wake_fall |=> !state_reg.wake_flag)
    else $error("data read did not clear wake flag");
  overrun_a: assert property (frame_done && keep_frame && state_reg.full && !rd_rx_data
                              |=> state_reg.overrun_error_flag)
    else $error("overrun not flagged");
  addr_filter_a: assert property (frame_done && !keep_frame
                                  |=> state_reg.rdata == $past(state_reg.rdata))
    else $error("data frame entered buffer in address mode");
  irq_route_a: assert property (irq_high_o |-> state_reg.receive_interrupt_priority && receive_complete_flag && !irq_low_o)
    else $error("interrupt on wrong priority level");
  frame_load_a: assert property (frame_done && keep_frame && !state_reg.full
                                 |=> state_reg.full && state_reg.rdata == $past(frame_byte))
    else $error("completed frame not loaded");

  frame_c: cover property (frame_done && keep_frame);
  wake_c: cover property (wake_fall ##[1:1000] wake_rise);
  overrun_c: cover property ($rose(state_reg.overrun_error_flag));
  framing_error_flag_c: cover property ($rose(state_reg.framing_error_flag));

endmodule : asrw_receiver // asrw_receiver

`default_nettype wire

// ==== asrw_serial_tx.sv ====
// remote serial transmitter model driving the receive line
`timescale 1ns/10ps
`default_nettype none

module asrw_serial_tx (
  // clock
  input  wire logic        core_clk_i,
  // frame request
  input  wire logic        send_i,
  input  wire logic [11:0] data_i,
  input  wire logic [3:0]  nbits_i,
  input  wire logic [15:0] period_i,
  input  wire logic        bad_stop_i,
  // serial line
  output var logic         line_o,
  output var logic         busy_o
);
  int i;

  // ==================================================
  // frame sender, idle line high between frames
  // start, data, stop
  always begin
    line_o <= 1'b1;
    repeat (period_i) @(posedge core_clk_i);
    busy_o <= 1'b0;
    @(posedge core_clk_i iff send_i);
    busy_o <= 1'b1;
    line_o <= 1'b0;
    repeat (period_i) @(posedge core_clk_i);
    for (i = 0; i < nbits_i; i++) begin
      line_o <= data_i[i];
      repeat (period_i) @(posedge core_clk_i);
    end
    line_o <= ~bad_stop_i;
    repeat (period_i) @(posedge core_clk_i);
  end
endmodule // asrw_serial_tx
`default_nettype wire

// ==== asrw_receiver_bench.sv ====
// self-checking bench of the serial receiver with wake-up
`timescale 1ns/10ps
`default_nettype none

module asrw_receiver_bench;
  import asrw_pkg::*;

  // ==================================================
  // signals
  localparam logic [7:0]  ST_SP   = 8'(1 << BIT_SERIAL_PORT_ENABLE);
  localparam logic [7:0]  ST_ON   = ST_SP | 8'(1 << BIT_CONTINUOUS_RECEIVE_ENABLE);
  localparam logic [7:0]  ST_RX9  = 8'(1 << BIT_RX9);
  localparam logic [7:0]  FLAG    = 8'(1 << BIT_RX_CPL);
  localparam logic [7:0]  DIV16   = 8'(1 << BIT_DIV16);
  localparam logic [31:0] NO_IDLE = ~(32'h00000001 << BIT_RX_IDLE);
  logic          core_clk_i = 1'b0;
  logic          rst_n_i    = 1'b0;
  logic          sleep_i    = 1'b0;
  logic          hreadyout_o;
  logic          hresp_o;
  logic [31:0]   hrdata_o;
  logic          irq_high_o;
  logic          irq_low_o;
  logic          rx_line;
  logic          tx_send    = 1'b0;
  logic [11:0]   tx_data    = 12'h000;
  logic [3:0]    tx_nbits   = 4'h8;
  logic [15:0]   tx_period  = 16'h0020;
  logic          tx_bad     = 1'b0;
  logic          tx_busy;
  logic          rd_dp      = 1'b0;
  asrw_ahb_req_s ahb_m      = '0;
  asrw_ahb_req_s ahb_in;
  logic [63:0]   exp_q[$];
  logic [31:0]   seed       = 32'h0000005D;
  int            n_fail     = 0;
  int            checks     = 0;

  always #2.5 core_clk_i = ~core_clk_i;
  always_comb begin
    ahb_in        = ahb_m;
    ahb_in.hready = hreadyout_o;
  end

  asrw_receiver i_dut (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .ahb_i(ahb_in),
    .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o),
    .receive_line_i(rx_line), .sleep_i(sleep_i),
    .irq_high_o(irq_high_o), .irq_low_o(irq_low_o));

  asrw_serial_tx i_tx (
    .core_clk_i(core_clk_i), .send_i(tx_send), .data_i(tx_data), .nbits_i(tx_nbits),
    .period_i(tx_period), .bad_stop_i(tx_bad), .line_o(rx_line), .busy_o(tx_busy));

  // ==================================================
  // helpers
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check_rd(input logic [63:0] e);
    checks++;
    if ((hrdata_o & e[63:32]) !== e[31:0]) begin
      n_fail++;
      $display("ERROR read data expected %h seen %h", e[31:0], hrdata_o);
    end
    checks++;
    if (hresp_o !== 1'b0) begin
      n_fail++;
      $display("ERROR hresp expected 0 seen %b", hresp_o);
    end
  endtask

  task automatic check_irq(input logic [1:0] e);
    #1;
    checks++;
    if ({irq_high_o, irq_low_o} !== e) begin
      n_fail++;
      $display("ERROR irq lines expected %b seen %b", e, {irq_high_o, irq_low_o});
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [63:0] v, input logic c);
    @(posedge core_clk_i);
    ahb_m.hsel   <= 1'b1;
    ahb_m.htrans <= 2'b10;
    ahb_m.haddr  <= {24'h000000, a};
    ahb_m.hwrite <= w;
    ahb_m.hsize  <= 3'b010;
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    ahb_m.hsel   <= 1'b0;
    ahb_m.htrans <= 2'b00;
    ahb_m.hwdata <= w ? v[31:0] : 32'h00000000;
    if (c) begin
      exp_q.push_back(v);
      rd_dp <= 1'b1;
    end
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    rd_dp <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    xfer(1'b1, a, {32'h00000000, 24'h000000, v}, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] v, input logic [31:0] m = '1);
    xfer(1'b0, a, {m, 24'h000000, v}, 1'b1);
  endtask

  task automatic send(input logic [11:0] d, input logic [3:0] n, input logic bad);
    @(posedge core_clk_i);
    tx_send  <= 1'b1;
    tx_data  <= d;
    tx_nbits <= n;
    tx_bad   <= bad;
    @(posedge core_clk_i);
    tx_send <= 1'b0;
    @(posedge core_clk_i);
    while (tx_busy) @(posedge core_clk_i);
  endtask

  // ==================================================
  // read data monitor
  always @(posedge core_clk_i) begin
    if (rd_dp) begin
      check_rd(exp_q.pop_front());
    end
  end

  // ==================================================
  // watchdog
  initial begin : watchdog
    repeat (50000) @(posedge core_clk_i);
    n_fail++;
    complete_run();
  end

  // ==================================================
  // scenarios
  initial begin : main
    logic [7:0] b;
    logic [7:0] b2;
    int         m;
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    for (m = 0; m < 10; m++) rd(8'(m * 4), 8'h00, (m == 6) ? NO_IDLE : '1);
    wr(OFS_IRQ_FLAGS, 8'hFF);
    rd(OFS_IRQ_FLAGS, 8'h00);
    wr(OFS_RX_STATUS, ST_ON);
    for (m = 0; m < 4; m++) begin
      wr(OFS_TX_STATUS, 8'(m % 2) << BIT_HS_BAUD);
      wr(OFS_BAUD_CTL, 8'(m / 2) << BIT_DIV16);
      wr(OFS_DIV_LOW, (m == 0) ? 8'h00 : (m == 3) ? 8'h07 : 8'h01);
      wr(OFS_IRQ_ENABLES, 8'(m % 2) << BIT_RX_CPL);
      wr(OFS_IRQ_PRIO, 8'(m / 2) << BIT_RX_CPL);
      tx_period <= (m == 0) ? 16'h0040 : 16'h0020;
      b = rnd();
      send({4'h0, b}, 4'h8, 1'b0);
      rd(OFS_IRQ_FLAGS, FLAG);
      check_irq({m == 3, m == 1});
      rd(OFS_RX_DATA, b);
      rd(OFS_IRQ_FLAGS, 8'h00);
    end
    wr(OFS_RX_STATUS, ST_ON | ST_RX9);
    b  = rnd();
    b2 = rnd();
    send({4'h1, b}, 4'h9, 1'b0);
    rd(OFS_RX_STATUS, ST_ON | ST_RX9 | 8'h01);
    rd(OFS_RX_DATA, b);
    wr(OFS_RX_STATUS, ST_ON | ST_RX9 | 8'(1 << BIT_ADDRESS_DETECT_ENABLE));
    send({4'h0, b}, 4'h9, 1'b0);
    rd(OFS_IRQ_FLAGS, 8'h00);
    check_irq(2'b00);
    send({4'h1, b2}, 4'h9, 1'b0);
    rd(OFS_IRQ_FLAGS, FLAG);
    rd(OFS_RX_DATA, b2);
    wr(OFS_RX_STATUS, ST_ON | ST_RX9);
    send({4'h0, b}, 4'h9, 1'b0);
    send({4'h0, b2}, 4'h9, 1'b0);
    rd(OFS_RX_STATUS, ST_ON | ST_RX9 | 8'(1 << BIT_OVERRUN_ERROR_FLAG));
    rd(OFS_RX_DATA, b);
    send({4'h0, b2}, 4'h9, 1'b1);
    rd(OFS_RX_STATUS, ST_ON | ST_RX9 | 8'(1 << BIT_OVERRUN_ERROR_FLAG) | 8'(1 << BIT_FRAMING_ERROR_FLAG));
    xfer(1'b0, OFS_RX_DATA, 64'h0, 1'b0);
    wr(OFS_RX_STATUS, ST_SP | ST_RX9);
    rd(OFS_RX_STATUS, ST_SP | ST_RX9);
    send({4'h0, b}, 4'h9, 1'b0);
    rd(OFS_IRQ_FLAGS, 8'h00);
    wr(OFS_RX_STATUS, ST_ON | ST_RX9);
    wr(OFS_TX_STATUS, 8'h14);
    send({4'h0, b}, 4'h9, 1'b0);
    rd(OFS_IRQ_FLAGS, 8'h00);
    wr(OFS_TX_STATUS, 8'h04);
    sleep_i <= 1'b1;
    send({4'h0, b}, 4'h9, 1'b0);
    rd(OFS_IRQ_FLAGS, 8'h00);
    // no wake while synchronous mode is selected
    wr(OFS_TX_STATUS, 8'h14);
    wr(OFS_BAUD_CTL, DIV16 | 8'(1 << BIT_WAKE));
    send(12'h000, 4'hC, 1'b0);
    rd(OFS_IRQ_FLAGS, 8'h00);
    wr(OFS_TX_STATUS, 8'h04);
    wr(OFS_BAUD_CTL, DIV16 | 8'(1 << BIT_WAKE));
    send(12'h000, 4'hC, 1'b0);
    rd(OFS_IRQ_FLAGS, FLAG);
    check_irq(2'b10);
    rd(OFS_BAUD_CTL, DIV16, NO_IDLE);
    sleep_i <= 1'b0;
    rd(OFS_RX_STATUS, ST_ON | ST_RX9);
    xfer(1'b0, OFS_RX_DATA, 64'h0, 1'b0);
    rd(OFS_IRQ_FLAGS, 8'h00);
    b = rnd();
    send({4'h0, b}, 4'h9, 1'b0);
    rd(OFS_RX_DATA, b);
    repeat (2) @(posedge core_clk_i);
    complete_run();
  end
endmodule // asrw_receiver_bench
`default_nettype wire
